// ===== fswc_top.sv
// fpu state-word control: system control bits, status and control words,
// tag word load and rebuild, with an axi4-lite slave for software
// assumes the integer unit holds op.valid until opReady is high
`timescale 1ns/1ps
`include "fswc_map.svh"
module fswc_top #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// axi4-lite write
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic      [1:0]        bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	// axi4-lite read
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic      [31:0]       rdata,
	output logic      [1:0]        rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// integer unit side
	input  fswc_pkg::fswc_op_t     op,
	output logic                   opReady,
	input  fswc_pkg::fswc_dwr_t    dataWr,
	output fswc_pkg::fswc_rsp_t    rsp,
	// interrupt
	output logic                   irq
);
	import fswc_pkg::*;

	// ****************************************
	// functions
	// ****************************************
	function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic isMapped(input logic [ADDR_W-1:0] a);
		logic [7:0] o;
		o = a[7:0];
		return (o == `FSWC_OFF_SYSCTL) || (o == `FSWC_OFF_CTRL) || (o == `FSWC_OFF_STAT) ||
			(o == `FSWC_OFF_TAG) || (o == `FSWC_OFF_IRQSTAT) || (o == `FSWC_OFF_IRQMASK);
	endfunction

	function automatic logic [1:0] classify(input logic [79:0] v);
		logic [14:0] e;
		logic [1:0]  t;
		e = v[78:64];
		if (e == 15'h0000 && v[63:0] == 64'h0000000000000000) begin
			t = `FSWC_TAG_ZERO;
		end else if (e == 15'h0000 || e == `FSWC_EXP_MAX || !v[63]) begin
			t = `FSWC_TAG_SPECIAL;
		end else begin
			t = `FSWC_TAG_VALID;
		end
		return t;
	endfunction

	// ****************************************
	// declarations
	// ****************************************
	logic              awHeld_r, awHeld_nxt;
	logic [ADDR_W-1:0] awAddr_r, awAddr_nxt;
	logic              wHeld_r, wHeld_nxt;
	logic [31:0]       wData_r, wData_nxt;
	logic [3:0]        wStrb_r, wStrb_nxt;
	logic              awready_r, awready_nxt;
	logic              wready_r, wready_nxt;
	logic              bvalid_r, bvalid_nxt;
	logic [1:0]        bresp_r, bresp_nxt;
	logic              arready_r, arready_nxt;
	logic              rvalid_r, rvalid_nxt;
	logic [31:0]       rdata_r, rdata_nxt;
	logic [1:0]        rresp_r, rresp_nxt;
	logic [31:0]       sysCtl_r, sysCtl_nxt;
	logic [15:0]       ctrl_r, ctrl_nxt;
	logic [31:0]       irqStat_r, irqStat_nxt;
	logic [31:0]       irqMask_r, irqMask_nxt;
	logic              irq_r, irq_nxt;
	logic [31:0]       events;

	fswc_state_t       state_r, state_nxt;
	logic [2:0]        idx_r, idx_nxt;
	logic [15:0]       stat_r, stat_nxt;
	logic [7:0]        empty_r, empty_nxt;
	logic [15:0]       tagAcc_r, tagAcc_nxt;
	logic [15:0]       tagOut_r, tagOut_nxt;
	fswc_rsp_t         rsp_r, rsp_nxt;
	logic              opReady_r, opReady_nxt;
	logic              rdEn;
	logic [79:0]       rdData;
	logic              evDna, evMf, evExt, evStk;

	assign awready = awready_r;
	assign wready  = wready_r;
	assign bvalid  = bvalid_r;
	assign bresp   = bresp_r;
	assign arready = arready_r;
	assign rvalid  = rvalid_r;
	assign rdata   = rdata_r;
	assign rresp   = rresp_r;
	assign irq     = irq_r;
	assign rsp     = rsp_r;
	assign opReady = opReady_r;

	// ****************************************
	// register bus
	// ****************************************
	always_comb begin
		logic [31:0] merged;
		logic [7:0]  wOff;
		logic [7:0]  rOff;
		merged      = '0;
		wOff        = awAddr_r[7:0];
		rOff        = araddr[7:0];
		awHeld_nxt  = awHeld_r;
		awAddr_nxt  = awAddr_r;
		wHeld_nxt   = wHeld_r;
		wData_nxt   = wData_r;
		wStrb_nxt   = wStrb_r;
		bvalid_nxt  = bvalid_r;
		bresp_nxt   = bresp_r;
		arready_nxt = arready_r;
		rvalid_nxt  = rvalid_r;
		rdata_nxt   = rdata_r;
		rresp_nxt   = rresp_r;
		sysCtl_nxt  = sysCtl_r;
		ctrl_nxt    = ctrl_r;
		irqStat_nxt = irqStat_r;
		irqMask_nxt = irqMask_r;
		if (awvalid && awready_r) begin
			awHeld_nxt = 1'b1;
			awAddr_nxt = awaddr;
		end
		if (wvalid && wready_r) begin
			wHeld_nxt = 1'b1;
			wData_nxt = wdata;
			wStrb_nxt = wstrb;
		end
		if (bvalid_r && bready) begin
			bvalid_nxt = 1'b0;
		end
		if (awHeld_r && wHeld_r && !bvalid_r) begin
			awHeld_nxt = 1'b0;
			wHeld_nxt  = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt  = isMapped(awAddr_r) ? `FSWC_RESP_OKAY : `FSWC_RESP_SLVERR;
			case (wOff)
				`FSWC_OFF_SYSCTL: begin
					merged     = mergeStrb(sysCtl_r, wData_r, wStrb_r);
					sysCtl_nxt = (merged & `FSWC_SYS_WMASK) | `FSWC_SYS_RST;
				end
				`FSWC_OFF_CTRL: begin
					merged   = mergeStrb({16'h0000, ctrl_r}, wData_r, wStrb_r);
					ctrl_nxt = merged[15:0];
				end
				`FSWC_OFF_IRQSTAT: begin
					merged      = wData_r & {{8{wStrb_r[3]}}, {8{wStrb_r[2]}},
						{8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
					irqStat_nxt = irqStat_r & ~merged;
				end
				`FSWC_OFF_IRQMASK: begin
					merged      = mergeStrb(irqMask_r, wData_r, wStrb_r);
					irqMask_nxt = merged & `FSWC_IRQ_WMASK;
				end
				default: begin
					merged = '0;
				end
			endcase
		end
		irqStat_nxt = irqStat_nxt | events;
		irq_nxt     = |(irqStat_nxt & irqMask_nxt);
		awready_nxt = !awHeld_nxt && !bvalid_nxt;
		wready_nxt  = !wHeld_nxt && !bvalid_nxt;
		if (rvalid_r && rready) begin
			rvalid_nxt  = 1'b0;
			arready_nxt = 1'b1;
		end
		if (arvalid && arready_r) begin
			arready_nxt = 1'b0;
			rvalid_nxt  = 1'b1;
			rresp_nxt   = isMapped(araddr) ? `FSWC_RESP_OKAY : `FSWC_RESP_SLVERR;
			case (rOff)
				`FSWC_OFF_SYSCTL:  rdata_nxt = sysCtl_r;
				`FSWC_OFF_CTRL:    rdata_nxt = {16'h0000, ctrl_r};
				`FSWC_OFF_STAT:    rdata_nxt = {16'h0000, stat_r};
				`FSWC_OFF_TAG:     rdata_nxt = {16'h0000, tagOut_r};
				`FSWC_OFF_IRQSTAT: rdata_nxt = irqStat_r;
				`FSWC_OFF_IRQMASK: rdata_nxt = irqMask_r;
				default:           rdata_nxt = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			awHeld_r  <= 1'b0;
			awAddr_r  <= '0;
			wHeld_r   <= 1'b0;
			wData_r   <= 32'h00000000;
			wStrb_r   <= 4'h0;
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			bvalid_r  <= 1'b0;
			bresp_r   <= `FSWC_RESP_OKAY;
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h00000000;
			rresp_r   <= `FSWC_RESP_OKAY;
			sysCtl_r  <= `FSWC_SYS_RST;
			ctrl_r    <= `FSWC_CTRL_RST;
			irqStat_r <= 32'h00000000;
			irqMask_r <= 32'h00000000;
			irq_r     <= 1'b0;
		end else begin
			awHeld_r  <= awHeld_nxt;
			awAddr_r  <= awAddr_nxt;
			wHeld_r   <= wHeld_nxt;
			wData_r   <= wData_nxt;
			wStrb_r   <= wStrb_nxt;
			awready_r <= awready_nxt;
			wready_r  <= wready_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			arready_r <= arready_nxt;
			rvalid_r  <= rvalid_nxt;
			rdata_r   <= rdata_nxt;
			rresp_r   <= rresp_nxt;
			sysCtl_r  <= sysCtl_nxt;
			ctrl_r    <= ctrl_nxt;
			irqStat_r <= irqStat_nxt;
			irqMask_r <= irqMask_nxt;
			irq_r     <= irq_nxt;
		end
	end

	// ****************************************
	// operations, status word and tags
	// ****************************************
	always_comb begin
		logic [1:0] t;
		logic       report;
		t           = `FSWC_TAG_EMPTY;
		report      = 1'b0;
		state_nxt   = state_r;
		idx_nxt     = idx_r;
		stat_nxt    = stat_r;
		empty_nxt   = empty_r;
		tagAcc_nxt  = tagAcc_r;
		tagOut_nxt  = tagOut_r;
		rsp_nxt     = '0;
		rdEn        = 1'b0;
		evDna       = 1'b0;
		evStk       = 1'b0;
		if (dataWr.en) begin
			empty_nxt[dataWr.idx] = 1'b0;
		end
		case (state_r)
			FSWC_IDLE: begin
				if (op.valid) begin
					case (op.kind)
						FSWC_OP_INIT: begin
							stat_nxt  = `FSWC_STAT_RST;
							empty_nxt = `FSWC_EMPTY_RST;
						end
						FSWC_OP_WAIT: begin
							if (sysCtl_r[`FSWC_SYS_MON] && sysCtl_r[`FSWC_SYS_TSW]) begin
								evDna             = 1'b1;
								rsp_nxt.excValid  = 1'b1;
								rsp_nxt.excVector = `FSWC_VEC_DNA;
							end
						end
						FSWC_OP_PREM: begin
							if (op.incomplete) begin
								stat_nxt[`FSWC_ST_CC0] = 1'b0;
								stat_nxt[`FSWC_ST_CC1] = 1'b0;
								stat_nxt[`FSWC_ST_CC3] = 1'b0;
								stat_nxt[`FSWC_ST_CC2] = 1'b1;
							end else begin
								stat_nxt[`FSWC_ST_CC0] = op.ccIn[0];
								stat_nxt[`FSWC_ST_CC1] = op.ccIn[1];
								stat_nxt[`FSWC_ST_CC2] = op.ccIn[2];
								stat_nxt[`FSWC_ST_CC3] = op.ccIn[3];
							end
						end
						FSWC_OP_PTAN: begin
							stat_nxt[`FSWC_ST_CC2] = op.outOfRange;
						end
						FSWC_OP_STACK: begin
							stat_nxt[`FSWC_ST_INV]  = 1'b1;
							stat_nxt[`FSWC_ST_STKF] = 1'b1;
							stat_nxt[`FSWC_ST_CC1]  = op.overflow;
							evStk                   = 1'b1;
							report                = 1'b1;
						end
						FSWC_OP_EXC: begin
							report = 1'b1;
						end
						FSWC_OP_ENV_LOAD: begin
							for (int i = 0; i < `FSWC_NREG; i++) begin
								empty_nxt[i] = (op.tagWord[2*i +: 2] == `FSWC_TAG_EMPTY);
							end
						end
						FSWC_OP_ENV_STORE: begin
							state_nxt  = FSWC_ISSUE;
							idx_nxt    = 3'h0;
							tagAcc_nxt = 16'h0000;
						end
						default: begin
							report = 1'b0;
						end
					endcase
				end
			end
			FSWC_ISSUE: begin
				rdEn      = 1'b1;
				state_nxt = FSWC_CAPT;
			end
			FSWC_CAPT: begin
				t = classify(rdData);
				if (empty_r[idx_r]) begin
					t = `FSWC_TAG_EMPTY;
				end
				tagAcc_nxt[{idx_r, 1'b0} +: 2] = t;
				if (idx_r == 3'h7) begin
					state_nxt        = FSWC_IDLE;
					tagOut_nxt       = tagAcc_nxt;
					rsp_nxt.tagValid = 1'b1;
					rsp_nxt.tagWord  = tagAcc_nxt;
				end else begin
					idx_nxt   = idx_r + 3'h1;
					state_nxt = FSWC_ISSUE;
				end
			end
			default: begin
				state_nxt = FSWC_IDLE;
			end
		endcase
		evMf  = report && sysCtl_r[`FSWC_SYS_NATIVE];
		evExt = report && !sysCtl_r[`FSWC_SYS_NATIVE];
		if (evMf) begin
			rsp_nxt.excValid  = 1'b1;
			rsp_nxt.excVector = `FSWC_VEC_MF;
		end
		rsp_nxt.extErr = evExt;
		opReady_nxt    = (state_nxt == FSWC_IDLE);
	end

	always_comb begin
		events                 = 32'h00000000;
		events[`FSWC_IRQ_DNA]  = evDna;
		events[`FSWC_IRQ_MF]   = evMf;
		events[`FSWC_IRQ_EXT]  = evExt;
		events[`FSWC_IRQ_STK]  = evStk;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r   <= FSWC_IDLE;
			idx_r     <= 3'h0;
			stat_r    <= `FSWC_STAT_RST;
			empty_r   <= `FSWC_EMPTY_RST;
			tagAcc_r  <= 16'h0000;
			tagOut_r  <= 16'hffff;
			rsp_r     <= '0;
			opReady_r <= 1'b1;
		end else begin
			state_r   <= state_nxt;
			idx_r     <= idx_nxt;
			stat_r    <= stat_nxt;
			empty_r   <= empty_nxt;
			tagAcc_r  <= tagAcc_nxt;
			tagOut_r  <= tagOut_nxt;
			rsp_r     <= rsp_nxt;
			opReady_r <= opReady_nxt;
		end
	end

	// ****************************************
	// data registers
	// ****************************************
	fswc_data_mem #(
		.DEPTH(`FSWC_NREG),
		.WIDTH(80)
	) u_mem (
		.clk   (clk),
		.rst   (rst),
		.wrEn  (dataWr.en),
		.wrAddr(dataWr.idx),
		.wrData(dataWr.value),
		.rdEn  (rdEn),
		.rdAddr(idx_r),
		.rdData(rdData)
	);
endmodule

// ===== fswc_map.svh
// constants of the fpu state-word control block: offsets, bit positions,
// reset values and encodings; assumes a 32-bit axi4-lite register bus
`ifndef FSWC_MAP_SVH
`define FSWC_MAP_SVH

// ****************************************
// register offsets
// ****************************************
`define FSWC_OFF_SYSCTL  8'h00
`define FSWC_OFF_CTRL    8'h04
`define FSWC_OFF_STAT    8'h08
`define FSWC_OFF_TAG     8'h0c
`define FSWC_OFF_IRQSTAT 8'h10
`define FSWC_OFF_IRQMASK 8'h14

// ****************************************
// field positions
// ****************************************
`define FSWC_SYS_MON     1
`define FSWC_SYS_TSW     3
`define FSWC_SYS_EXTTYPE 4
`define FSWC_SYS_NATIVE  5
`define FSWC_ST_INV  0
`define FSWC_ST_STKF 6
`define FSWC_ST_CC0  8
`define FSWC_ST_CC1  9
`define FSWC_ST_CC2  10
`define FSWC_ST_CC3  14
`define FSWC_CW_IC   12
`define FSWC_IRQ_DNA 0
`define FSWC_IRQ_MF  1
`define FSWC_IRQ_EXT 2
`define FSWC_IRQ_STK 3

// ****************************************
// reset values, masks and encodings
// ****************************************
`define FSWC_SYS_RST     32'h00000010
`define FSWC_SYS_WMASK   32'h0000002a
`define FSWC_CTRL_RST    16'h037f
`define FSWC_STAT_RST    16'h0000
`define FSWC_EMPTY_RST   8'hff
`define FSWC_IRQ_WMASK   32'h0000000f
`define FSWC_VEC_DNA     8'h07
`define FSWC_VEC_MF      8'h10
`define FSWC_TAG_VALID   2'h0
`define FSWC_TAG_ZERO    2'h1
`define FSWC_TAG_SPECIAL 2'h2
`define FSWC_TAG_EMPTY   2'h3
`define FSWC_EXP_MAX     15'h7fff
`define FSWC_NREG        8
`define FSWC_RESP_OKAY   2'h0
`define FSWC_RESP_SLVERR 2'h2

`endif

// ===== fswc_pkg.sv
// types of the fpu state-word control block
// assumes fswc_map.svh for the constants
package fswc_pkg;

	typedef enum logic [3:0] {
		FSWC_OP_INIT,
		FSWC_OP_WAIT,
		FSWC_OP_PREM,
		FSWC_OP_PTAN,
		FSWC_OP_STACK,
		FSWC_OP_EXC,
		FSWC_OP_ENV_LOAD,
		FSWC_OP_ENV_STORE
	} fswc_opkind_t;

	typedef enum logic [1:0] {
		FSWC_IDLE,
		FSWC_ISSUE,
		FSWC_CAPT
	} fswc_state_t;

	typedef struct packed {
		logic         valid;
		fswc_opkind_t kind;
		logic [3:0]   ccIn;
		logic         incomplete;
		logic         outOfRange;
		logic         overflow;
		logic [15:0]  tagWord;
	} fswc_op_t;

	typedef struct packed {
		logic        en;
		logic [2:0]  idx;
		logic [79:0] value;
	} fswc_dwr_t;

	typedef struct packed {
		logic        excValid;
		logic [7:0]  excVector;
		logic        extErr;
		logic        tagValid;
		logic [15:0] tagWord;
	} fswc_rsp_t;

endpackage

// ===== fswc_data_mem.sv
// data register file of the fpu, one write port and one registered read port
// assumes a single clock and a synchronous active-high reset
`timescale 1ns/1ps
module fswc_data_mem #(
	parameter int DEPTH = 8,
	parameter int WIDTH = 80
) (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst,
	// write port
	input  wire logic                     wrEn,
	input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
	input  wire logic [WIDTH-1:0]         wrData,
	// read port
	input  wire logic                     rdEn,
	input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
	output logic      [WIDTH-1:0]         rdData
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] rdData_r;

	assign rdData = rdData_r;

	always_ff @(posedge clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
		if (rst) begin
			rdData_r <= '0;
		end else if (rdEn) begin
			rdData_r <= mem[rdAddr];
		end
	end
endmodule

// ===== fswc_top_asserts.sv
// port checker of fswc_top
// bound to fswc_top from the testbench top file
`timescale 1ns/1ps
module fswc_top_asserts (
	// clock and reset
	input wire logic          clk,
	input wire logic          rst,
	// bus handshakes
	input wire logic          awvalid,
	input wire logic          awready,
	input wire logic          wvalid,
	input wire logic          wready,
	input wire logic          bvalid,
	input wire logic          arvalid,
	input wire logic          arready,
	input wire logic          rvalid,
	// op port
	input fswc_pkg::fswc_op_t  op,
	input wire logic          opReady,
	input fswc_pkg::fswc_dwr_t dataWr,
	input fswc_pkg::fswc_rsp_t rsp
);
	import fswc_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	wire take = op.valid && opReady;
	wire takeSt = take && op.kind == FSWC_OP_ENV_STORE;
	wire takeWait = take && op.kind == FSWC_OP_WAIT;
	wire takeExc = take && (op.kind == FSWC_OP_EXC || op.kind == FSWC_OP_STACK);
	logic initLast_r;
	logic initLast_nxt;
	// last event, an op taken or a data write, was an initialise
	always_comb begin
		initLast_nxt = initLast_r;
		if (dataWr.en || take)
			initLast_nxt = !dataWr.en && take && op.kind == FSWC_OP_INIT;
	end
	always_ff @(posedge clk) begin
		if (rst)
			initLast_r <= 1'b1;
		else
			initLast_r <= initLast_nxt;
	end
	sequence seqStore;
		takeSt;
	endsequence
	sequence seqWalk;
		(!opReady)[*8] ##1 (!opReady)[*8] ##1 (opReady && rsp.tagValid);
	endsequence
	a_store_walk: assert property (seqStore |=> seqWalk)
		else $error("tag walk timing wrong");
	a_store_len: assert property (rsp.tagValid |-> $past(takeSt, 17))
		else $error("tag word without store");
	a_init_empty: assert property (takeSt && initLast_r |-> ##17 rsp.tagWord == 16'hffff)
		else $error("empty tags wrong");
	a_wait_trap: assert property (rsp.excValid && rsp.excVector == 8'h07 |-> $past(takeWait))
		else $error("vector 7 without wait");
	a_native_vec: assert property (rsp.excValid && rsp.excVector == 8'h10 |-> $past(takeExc))
		else $error("vector 16 without exception");
	a_ext_report: assert property (rsp.extErr |-> $past(takeExc) && !rsp.excValid)
		else $error("external report wrong");
	a_vec_legal: assert property (rsp.excValid |-> rsp.excVector inside {8'h07, 8'h10})
		else $error("illegal vector");
	a_b_answer: assert property (awvalid && awready && wvalid && wready && !bvalid |-> ##2 bvalid)
		else $error("write answer late");
	a_r_answer: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read answer late");
endmodule

// ===== fswc_iu_model.sv
// integer-unit model: one op on the op port per go pulse
// assumes go only while no op is pending
`timescale 1ns/1ps
module fswc_iu_model (
	// clock and reset
	input wire logic          clk,
	input wire logic          rst,
	// bench request
	input wire logic          go,
	input fswc_pkg::fswc_op_t req,
	output logic              done,
	// op port
	input wire logic          opReady,
	output fswc_pkg::fswc_op_t op
);
	import fswc_pkg::*;
	// valid held until taken, payload inverted once released
	always_ff @(posedge clk) begin
		if (rst) begin
			op <= '0;
			done <= 1'b0;
		end else begin
			done <= op.valid && opReady;
			if (go)
				op <= req;
			else if (op.valid && opReady)
				op <= fswc_op_t'({1'b0, ~op[$bits(fswc_op_t)-2:0]});
		end
	end
endmodule

// ===== tb.sv
// self-checking bench of fswc_top against a reference model
// assumes fswc_pkg, fswc_top, fswc_iu_model, fswc_top_asserts
`timescale 1ns/1ps
`define CHK(g, e) begin cmpCount++; if ((g) !== (e)) begin errTotal++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
	import fswc_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  awaddr = '0, araddr = '0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, go = 0;
	logic [31:0] wdata = '0, rdata, lfsr = 32'd76825, sys = 32'h10, istat = 0, imask = 0;
	logic        awready, wready, bvalid, arready, rvalid, irq, opReady, done;
	logic [1:0]  bresp, rresp;
	fswc_op_t    op, req = '0;
	fswc_dwr_t   dataWr = '0;
	fswc_rsp_t   rsp;
	int          errTotal = 0, cmpCount = 0;
	logic [15:0] ctrl = 16'h037f, st = 0, tagR = 16'hffff;
	logic [7:0]  emp = 8'hff;
	logic [79:0] val [8];
	logic [79:0] tv [8] = '{80'h0, {16'h3fff, 64'h8000000000000000},
		{16'h3fff, 64'h5}, {16'h0, 64'h8000000000000000}, {16'hffff, 64'h8000000000000001},
		{16'h8000, 64'h0}, {16'h1234, 64'h8000000000000007}, {16'h0, 64'h3}};
	fswc_opkind_t ks [5] = '{FSWC_OP_PREM, FSWC_OP_PTAN, FSWC_OP_STACK, FSWC_OP_INIT,
		FSWC_OP_WAIT};
	always #5 clk = ~clk;
	fswc_top i_dut (.clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .op(op), .opReady(opReady),
		.dataWr(dataWr), .rsp(rsp), .irq(irq));
	fswc_iu_model i_iu (.clk(clk), .rst(rst), .go(go), .req(req), .done(done),
		.opReady(opReady), .op(op));
	task automatic complete_run();
		$display("compares %0d mismatches %0d", cmpCount, errTotal);
		if (errTotal == 0 && cmpCount > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic hang(input int n, input int lim);
		if (n >= lim) begin
			errTotal++;
			complete_run();
		end
	endtask
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	function automatic logic [1:0] cls(input logic [79:0] v);
		if (v[78:0] == '0)
			return 2'h1;
		if (v[78:64] == 15'h0 || v[78:64] == 15'h7fff || !v[63])
			return 2'h2;
		return 2'h0;
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic [1:0] e;
		n = 0;
		e = 2'h0;
		case (a)
			8'h00: sys = (d & 32'h2a) | 32'h10;
			8'h04: ctrl = d[15:0];
			8'h10: istat = istat & ~d & 32'hf;
			8'h14: imask = d & 32'hf;
			default: e = 2'h2;
		endcase
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid && n < 50);
		bready <= 1'b0;
		hang(n, 50);
		`CHK(bresp, e)
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		logic [31:0] e;
		n = 0;
		e = a == 8'h00 ? sys : a == 8'h04 ? ctrl : a == 8'h08 ? st : a == 8'h0c ? tagR
			: a == 8'h10 ? istat : a == 8'h14 ? imask : 32'h0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid && n < 50);
		rready <= 1'b0;
		hang(n, 50);
		`CHK(rdata, e)
		`CHK(rresp, (a > 8'h14 ? 2'h2 : 2'h0))
	endtask
	task automatic dw(input int i, input logic [79:0] v);
		@(posedge clk);
		dataWr <= '{1'b1, 3'(i), v};
		@(posedge clk);
		dataWr.en <= 1'b0;
		val[i] = v;
		emp[i] = 1'b0;
	endtask
	task automatic issue(input fswc_op_t o);
		int n;
		logic ev, ex;
		logic [7:0] vec;
		{ev, ex, vec, n} = '0;
		case (o.kind)
			FSWC_OP_INIT: {st, emp} = {16'h0, 8'hff};
			FSWC_OP_WAIT: if (sys[1] && sys[3]) {ev, vec, istat[0]} = {1'b1, 8'h07, 1'b1};
			FSWC_OP_PREM: st = (st & 16'hb8ff) | (o.incomplete ? 16'h0400
				: {1'b0, o.ccIn[3], 3'h0, o.ccIn[2:0], 8'h00});
			FSWC_OP_PTAN: st[10] = o.outOfRange;
			FSWC_OP_STACK: {st[9], st[6], st[0], istat[3]} = {o.overflow, 3'h7};
			FSWC_OP_ENV_LOAD: for (int i = 0; i < 8; i++) emp[i] = o.tagWord[2*i +: 2] == 2'h3;
			FSWC_OP_ENV_STORE: for (int i = 0; i < 8; i++)
				tagR[2*i +: 2] = emp[i] ? 2'h3 : cls(val[i]);
			default: ;
		endcase
		if (o.kind inside {FSWC_OP_STACK, FSWC_OP_EXC}) begin
			if (sys[5])
				{ev, vec, istat[1]} = {1'b1, 8'h10, 1'b1};
			else
				{ex, istat[2]} = 2'h3;
		end
		o.valid = 1'b1;
		@(posedge clk);
		req <= o;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (!done && n < 50);
		hang(n, 50);
		`CHK(rsp.excValid, ev)
		`CHK(rsp.extErr, ex)
		if (ev) `CHK(rsp.excVector, vec)
		for (n = 0; n < 40 && o.kind == FSWC_OP_ENV_STORE && !rsp.tagValid; n++) begin
			@(posedge clk);
			#1;
		end
		hang(n, 40);
		if (o.kind == FSWC_OP_ENV_STORE) `CHK(rsp.tagWord, tagR)
		@(posedge clk);
		#1;
		`CHK(irq, |(istat[3:0] & imask[3:0]))
	endtask
	initial begin
		fswc_op_t o;
		logic [31:0] r;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (int a = 0; a < 32; a += 4) rd(8'(a));
		$display("test reset finished");
		wr(8'h00, 32'hffffffff);
		wr(8'h04, 32'h00001000);
		wr(8'h1c, 32'h1);
		for (int a = 0; a < 32; a += 4) rd(8'(a));
		wr(8'h04, rnd());
		rd(8'h04);
		$display("test registers finished");
		for (int k = 0; k < 8; k++) begin
			wr(8'h14, 32'(k) | 32'h2);
			wr(8'h00, 32'({k[2], 1'b0, k[1], 1'b0, k[0], 1'b0}));
			o = '0;
			o.kind = FSWC_OP_WAIT;
			issue(o);
			o.kind = FSWC_OP_EXC;
			issue(o);
			rd(8'h10);
			wr(8'h10, 32'hf);
			rd(8'h10);
			`CHK(irq, 1'b0)
		end
		$display("test traps finished");
		for (int j = 0; j < 15; j++) begin
			r = rnd();
			o = '0;
			o.kind = ks[j % 5];
			o.ccIn = r[3:0];
			{o.incomplete, o.outOfRange, o.overflow} = {3{j[0]}};
			issue(o);
			rd(8'h08);
		end
		$display("test status finished");
		for (int i = 0; i < 8; i++) dw(i, tv[i]);
		for (int j = 0; j < 3; j++) begin
			r = rnd();
			o = '0;
			o.kind = FSWC_OP_ENV_LOAD;
			o.tagWord = j == 0 ? 16'h0 : r[15:0];
			issue(o);
			o.kind = FSWC_OP_ENV_STORE;
			issue(o);
			rd(8'h0c);
		end
		o = '0;
		issue(o);
		o.kind = FSWC_OP_ENV_STORE;
		issue(o);
		$display("test tags finished");
		complete_run();
	end
endmodule
bind fswc_top fswc_top_asserts u_chk (.clk(clk), .rst(rst), .awvalid(awvalid),
	.awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
	.arvalid(arvalid), .arready(arready), .rvalid(rvalid), .op(op), .opReady(opReady),
	.dataWr(dataWr), .rsp(rsp));
